// ### ssp_regs.vh
// Constants for the superscalar pipeline control block.
// Included by ssp_pipeline.v; definitions only.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_ADDR_W 32
`define SSP_INSN_W 32
`define SSP_DATA_W 32
`define SSP_REG_AW 5
`define SSP_TAG_W 4
`define SSP_RESET_PC 32'h00000100
`define SSP_INSN_BYTES 32'h00000004
// Instruction class field [31:30]
`define SSP_CLS_HI 31
`define SSP_CLS_LO 30
`define SSP_CLS_INT 2'h0
`define SSP_CLS_FP 2'h1
`define SSP_CLS_LS 2'h2
`define SSP_CLS_BR 2'h3
// Field positions
`define SSP_RD_HI 29
`define SSP_RD_LO 25
`define SSP_RA_HI 24
`define SSP_RA_LO 20
`define SSP_RB_HI 19
`define SSP_RB_LO 15
`define SSP_BR_COND 14
`define SSP_IMM_HI 13
`define SSP_IMM_LO 0
// Unit depths
`define SSP_FP_STAGES 3
`define SSP_LS_STAGES 2
`endif

// ### ssp_pipeline.v
// Four-stage superscalar pipeline control: fetch, dispatch, execute, completion.
// Assumes the instruction cache answers in the same cycle, the data cache in one cycle,
// and the register file reads combinationally.
// Notes on behaviour
// - Instructions pass fetch, dispatch, execute and completion in that order.
// - Fetch pulls instructions from memory and computes the next fetch address.
// - Branches are decoded at fetch and folded out so they never reach dispatch.
// - Dispatch decodes fetched instructions and decides each cycle which are eligible.
// - Dispatch reads source operands from the register file and sends them to the integer and load/store units.
// - The integer and load/store units latch the tag and operands at the end of dispatch; the floating-point unit latches only the tag.
// - Units execute, possibly over several cycles, write a rename register and notify completion.
// - A unit reports an internal exception and keeps executing; fetch, dispatch and completion stop once it is signalled until it is handled.
// - An exception is only signalled once its instruction is next to complete.
// - The floating-point unit holds up to three instructions in flight.
// - The floating-point stages are multiply, add, then round-convert.
// - Load/store runs address and translation, then cache access.
// - Floating-point latency is three cycles with throughput of one per cycle.
`timescale 1ns/10ps
`include "ssp_regs.vh"
module ssp_pipeline (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Instruction cache
  output wire [31:0] ic_addr,
  output wire ic_req,
  input wire [31:0] ic_data,
  input wire ic_valid,
  // Branch condition from condition logic
  input wire br_taken,
  // Register file read ports
  output wire [4:0] rf_ra_addr,
  output wire [4:0] rf_rb_addr,
  input wire [31:0] rf_ra_data,
  input wire [31:0] rf_rb_data,
  // Translation and data cache
  output reg [31:0] ls_ea_q,
  output wire ls_req,
  input wire mmu_fault,
  input wire [31:0] dc_rdata,
  // Floating-point datapath: last-stage result, multiply-stage fault
  input wire [31:0] fp_result,
  input wire fp_fault,
  // Architectural commit
  output reg rf_we_q,
  output reg [4:0] rf_waddr_q,
  output reg [31:0] rf_wdata_q,
  // Exception delivery
  output reg exc_signal_q,
  output reg [31:0] exc_pc_q,
  input wire exc_handled,
  // Status
  output wire busy
);
  localparam ST_RUN = 2'h0;
  localparam ST_EXC = 2'h1;
  localparam ST_HOLD = 2'h2;
  localparam NTAG = 16;

  function [1:0] cls_of;
    input [31:0] insn;
    begin
      cls_of = insn[`SSP_CLS_HI:`SSP_CLS_LO];
    end
  endfunction

  // Immediate field widened to a full word, sign kept
  function [31:0] imm_ext;
    input [31:0] insn;
    begin
      imm_ext = {{18{insn[`SSP_IMM_HI]}}, insn[`SSP_IMM_HI:`SSP_IMM_LO]};
    end
  endfunction

  reg [1:0] state_q;
  reg [31:0] pc_q;
  // Fetch-to-dispatch latch
  reg fd_v_q;
  reg [31:0] fd_insn_q;
  reg [31:0] fd_pc_q;
  // Completion queue (in program order)
  reg [3:0] head_q;
  reg [3:0] tail_q;
  reg [NTAG-1:0] cq_v_q;
  reg [NTAG-1:0] cq_done_q;
  reg [NTAG-1:0] cq_exc_q;
  reg [4:0] cq_rd [0:NTAG-1];
  reg [31:0] cq_pc [0:NTAG-1];
  reg [31:0] ren_q [0:NTAG-1];
  // Integer unit
  reg iu_v_q;
  reg [3:0] iu_tag_q;
  reg [31:0] iu_a_q;
  reg [31:0] iu_b_q;
  // Floating-point stages: multiply, add, round-convert
  // Valid bits stay in one vector so a flush clears them together
  reg [2:0] fp_v_q;
  // Load/store stages
  reg ls_v_q;
  reg [3:0] ls_tag_q;
  reg [31:0] ls_a_q;
  reg [31:0] ls_b_q;
  reg ls2_v_q;
  reg [3:0] ls2_tag_q;
  reg ls2_exc_q;

  wire [31:0] di = fd_insn_q;
  wire [1:0] dcls = cls_of(di);
  wire cq_full = cq_v_q[tail_q];
  wire halted = (state_q != ST_RUN);
  // Eligibility: unit free this cycle and room to track it
  wire elig = fd_v_q & ~cq_full & ~halted &
              ((dcls == `SSP_CLS_INT) | (dcls == `SSP_CLS_FP) | ((dcls == `SSP_CLS_LS) & ~ls_v_q));
  wire disp = elig;
  wire fd_free = ~fd_v_q | disp;

  // Fetch and branch folding
  wire [1:0] fcls = cls_of(ic_data);
  wire fetch_ok = ic_valid & fd_free & ~halted;
  wire is_br = fetch_ok & (fcls == `SSP_CLS_BR);
  wire take = is_br & (~ic_data[`SSP_BR_COND] | br_taken);
  // Target is relative to the branch itself, not to the next word
  wire [31:0] br_tgt = pc_q + imm_ext(ic_data);
  wire [31:0] pc_d = take ? br_tgt : (fetch_ok ? pc_q + `SSP_INSN_BYTES : pc_q);

  assign ic_addr = pc_q;
  assign ic_req = fd_free & ~halted;
  assign rf_ra_addr = di[`SSP_RA_HI:`SSP_RA_LO];
  assign rf_rb_addr = di[`SSP_RB_HI:`SSP_RB_LO];
  assign ls_req = ls2_v_q;
  assign busy = |cq_v_q;

  wire ls_exc1 = ls_v_q & mmu_fault;
  wire fp_exc_in = fp_v_q[0] & fp_fault;
  wire head_ready = cq_v_q[head_q] & cq_done_q[head_q];
  wire retire = head_ready & ~cq_exc_q[head_q] & ~halted;
  wire raise = head_ready & cq_exc_q[head_q] & (state_q == ST_RUN);

  // Tag and fault flag ride along with each floating-point stage.
  // A fault seen in the multiply stage is carried to the last stage,
  // so completion learns of it only when the result would be written.
  genvar g;
  generate
    for (g = 0; g < `SSP_FP_STAGES; g = g + 1) begin : g_fp
      reg [3:0] tag_q;
      reg exc_q;
      wire [3:0] tag_d;
      wire exc_d;
      if (g == 0) begin : g_first
        assign tag_d = tail_q;
        assign exc_d = 1'b0;
      end else if (g == 1) begin : g_second
        assign tag_d = g_fp[0].tag_q;
        assign exc_d = fp_exc_in;
      end else begin : g_rest
        assign tag_d = g_fp[g-1].tag_q;
        assign exc_d = g_fp[g-1].exc_q;
      end
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          tag_q <= 4'h0;
          exc_q <= 1'b0;
        end else begin
          tag_q <= tag_d;
          exc_q <= exc_d;
        end
      end
    end
  endgenerate

  wire [3:0] fp_done_tag = g_fp[2].tag_q;
  wire fp_done_exc = g_fp[2].exc_q;

  integer i;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      pc_q <= `SSP_RESET_PC;
      fd_v_q <= 1'b0;
      fd_insn_q <= 32'h00000000;
      fd_pc_q <= 32'h00000000;
      head_q <= 4'h0;
      tail_q <= 4'h0;
      cq_v_q <= {NTAG{1'b0}};
      cq_done_q <= {NTAG{1'b0}};
      cq_exc_q <= {NTAG{1'b0}};
      iu_v_q <= 1'b0;
      iu_tag_q <= 4'h0;
      iu_a_q <= 32'h00000000;
      iu_b_q <= 32'h00000000;
      fp_v_q <= 3'h0;
      ls_v_q <= 1'b0;
      ls_tag_q <= 4'h0;
      ls_a_q <= 32'h00000000;
      ls_b_q <= 32'h00000000;
      ls2_v_q <= 1'b0;
      ls2_tag_q <= 4'h0;
      ls2_exc_q <= 1'b0;
      ls_ea_q <= 32'h00000000;
      rf_we_q <= 1'b0;
      rf_waddr_q <= 5'h00;
      rf_wdata_q <= 32'h00000000;
      exc_signal_q <= 1'b0;
      exc_pc_q <= 32'h00000000;
      for (i = 0; i < NTAG; i = i + 1) begin
        cq_rd[i] <= 5'h00;
        cq_pc[i] <= 32'h00000000;
        ren_q[i] <= 32'h00000000;
      end
    end else begin
      pc_q <= pc_d;
      // Fetch to dispatch; folded branches never enter the latch
      if (fd_free) begin
        fd_v_q <= fetch_ok & ~is_br;
        fd_insn_q <= ic_data;
        fd_pc_q <= pc_q;
      end
      // Dispatch: allocate tag, latch into the unit with operands
      iu_v_q <= disp & (dcls == `SSP_CLS_INT);
      ls_v_q <= disp & (dcls == `SSP_CLS_LS);
      if (disp) begin
        cq_v_q[tail_q] <= 1'b1;
        cq_rd[tail_q] <= di[`SSP_RD_HI:`SSP_RD_LO];
        cq_pc[tail_q] <= fd_pc_q;
        tail_q <= tail_q + 4'h1;
        iu_tag_q <= tail_q;
        iu_a_q <= rf_ra_data;
        iu_b_q <= rf_rb_data;
        ls_tag_q <= tail_q;
        ls_a_q <= rf_ra_data;
        // Register zero as index selects the immediate form
        ls_b_q <= (di[`SSP_RB_HI:`SSP_RB_LO] == 5'h00) ?
                  imm_ext(di) : rf_rb_data;
      end
      // Integer execute: one cycle into rename
      if (iu_v_q) begin
        ren_q[iu_tag_q] <= iu_a_q + iu_b_q;
        cq_done_q[iu_tag_q] <= 1'b1;
      end
      // Floating point: three stages, a new entry each cycle
      fp_v_q <= {fp_v_q[1:0], disp & (dcls == `SSP_CLS_FP)};
      // Faulted results are still written; retire refuses them later
      if (fp_v_q[2]) begin
        ren_q[fp_done_tag] <= fp_result;
        cq_done_q[fp_done_tag] <= 1'b1;
        cq_exc_q[fp_done_tag] <= fp_done_exc;
      end
      // Load/store: address and translation, then cache access
      ls2_v_q <= ls_v_q & ~ls_exc1;
      ls2_tag_q <= ls_tag_q;
      ls2_exc_q <= 1'b0;
      if (ls_v_q) begin
        ls_ea_q <= ls_a_q + ls_b_q;
        if (ls_exc1) begin
          cq_done_q[ls_tag_q] <= 1'b1;
          cq_exc_q[ls_tag_q] <= 1'b1;
        end
      end
      if (ls2_v_q) begin
        ren_q[ls2_tag_q] <= dc_rdata;
        cq_done_q[ls2_tag_q] <= 1'b1;
      end
      // Completion in program order
      rf_we_q <= retire;
      if (retire) begin
        rf_waddr_q <= cq_rd[head_q];
        rf_wdata_q <= ren_q[head_q];
        cq_v_q[head_q] <= 1'b0;
        cq_done_q[head_q] <= 1'b0;
        head_q <= head_q + 4'h1;
      end
      exc_signal_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (raise) begin
            exc_signal_q <= 1'b1;
            exc_pc_q <= cq_pc[head_q];
            state_q <= ST_EXC;
          end
        end
        ST_EXC: begin
          if (exc_handled) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Flush everything, the faulting instruction included; restart at the faulting address
          cq_v_q <= {NTAG{1'b0}};
          cq_done_q <= {NTAG{1'b0}};
          cq_exc_q <= {NTAG{1'b0}};
          head_q <= 4'h0;
          tail_q <= 4'h0;
          fd_v_q <= 1'b0;
          iu_v_q <= 1'b0;
          ls_v_q <= 1'b0;
          ls2_v_q <= 1'b0;
          fp_v_q <= 3'h0;
          pc_q <= exc_pc_q;
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end
endmodule

// ### ssp_pipeline_monitor.sv
// Port checker for the pipeline control block.
// Assumes one clock and an async active-high reset.
`timescale 1ns/10ps
module ssp_pipeline_monitor (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Fetch side
  input wire [31:0] ic_addr,
  input wire ic_req,
  input wire [31:0] ic_data,
  input wire ic_valid,
  input wire br_taken,
  // Results
  input wire rf_we_q,
  input wire ls_req,
  input wire exc_signal_q,
  input wire busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire tk = ic_valid && ic_req;
  wire [1:0] cls = ic_data[31:30];
  property p_pc; tk && cls != 2'h3 |=> ic_addr == $past(ic_addr) + 32'h4; endproperty
  a_pc: assert property (p_pc) else $error("fetch step");
  property p_nt; tk && cls == 2'h3 && ic_data[14] && !br_taken |=> ic_addr == $past(ic_addr) + 32'h4; endproperty
  a_nt: assert property (p_nt) else $error("not-taken step");
  property p_fold; tk && cls == 2'h3 && $past(tk && cls == 2'h3) && !busy |=> !busy; endproperty
  a_fold: assert property (p_fold) else $error("branch dispatched");
  property p_trk; tk && cls != 2'h3 |-> ##2 busy; endproperty
  a_trk: assert property (p_trk) else $error("fetch not tracked");
  property p_int; tk && cls == 2'h0 |-> ##[1:40] rf_we_q; endproperty
  a_int: assert property (p_int) else $error("int never commits");
  property p_fp; tk && cls == 2'h1 |-> ##[3:40] (rf_we_q || exc_signal_q); endproperty
  a_fp: assert property (p_fp) else $error("fp never done");
  property p_ls; tk && cls == 2'h2 |-> ##[2:40] ls_req; endproperty
  a_ls: assert property (p_ls) else $error("no cache access");
  property p_exc; exc_signal_q |=> !exc_signal_q; endproperty
  a_exc: assert property (p_exc) else $error("exc pulse long");
  property p_hold; exc_signal_q |=> (!ic_req && !rf_we_q) [*2]; endproperty
  a_hold: assert property (p_hold) else $error("ran on after exc");
  c_we: cover property (rf_we_q);
  c_ls: cover property (ls_req);
  c_exc: cover property (exc_signal_q);
endmodule
bind ssp_pipeline ssp_pipeline_monitor ssp_pipeline_monitor_i (.clock, .rst, .ic_addr, .ic_req, .ic_data,
  .ic_valid, .br_taken, .rf_we_q, .ls_req, .exc_signal_q, .busy);

// ### ssp_far_model.sv
// Far side: instruction cache, register file, data cache and fp result.
// Assumes the bench loads prog before releasing reset.
`timescale 1ns/10ps
module ssp_far_model (
  // Instruction cache
  input wire [31:0] ic_addr,
  output wire [31:0] ic_data,
  // Register file
  input wire [4:0] rf_ra_addr,
  input wire [4:0] rf_rb_addr,
  output wire [31:0] rf_ra_data,
  output wire [31:0] rf_rb_data,
  // Data cache and fp
  input wire ls_req,
  output wire [31:0] dc_rdata,
  output wire [31:0] fp_result
);
  logic [31:0] prog [0:15];
  // Outside the program every word is a branch to itself
  assign ic_data = ic_addr[31:6] == 26'h4 ? prog[ic_addr[5:2]] : 32'hC000_0000;
  assign rf_ra_data = {27'h0, rf_ra_addr} + 32'h1000;
  assign rf_rb_data = {27'h0, rf_rb_addr} + 32'h2000;
  // No stale data outside an access
  assign dc_rdata = ls_req ? 32'h0000_5A5A : {32{ic_addr[2]}};
  assign fp_result = 32'h3F80_0000;
endmodule

// ### ssp_pipeline_tb_top.sv
// Self-checking bench for the pipeline control block.
// Assumes the checker binds itself to the design.
`timescale 1ns/10ps
module ssp_pipeline_tb_top;
  logic clock = 0, rst = 1, ic_valid = 0, br_taken = 0, mmu_fault = 0, fp_fault = 0, exc_handled = 0, ls_seen = 0;
  wire [31:0] ic_addr, ic_data, rf_ra_data, rf_rb_data, ls_ea_q, dc_rdata, fp_result, rf_wdata_q, exc_pc_q;
  wire [4:0] rf_ra_addr, rf_rb_addr, rf_waddr_q;
  wire ic_req, ls_req, rf_we_q, exc_signal_q, busy;
  int mismatches = 0, tests_run = 0, n;
  always #50 clock = ~clock;
  always @(posedge clock) if (ls_req === 1'b1) ls_seen <= 1;
  ssp_pipeline ssp_pipeline_i (.clock, .rst, .ic_addr, .ic_req, .ic_data, .ic_valid, .br_taken, .rf_ra_addr,
    .rf_rb_addr, .rf_ra_data, .rf_rb_data, .ls_ea_q, .ls_req, .mmu_fault, .dc_rdata, .fp_result, .fp_fault,
    .rf_we_q, .rf_waddr_q, .rf_wdata_q, .exc_signal_q, .exc_pc_q, .exc_handled, .busy);
  ssp_far_model ssp_far_model_i (.ic_addr, .ic_data, .rf_ra_addr, .rf_rb_addr, .rf_ra_data, .rf_rb_data,
    .ls_req, .dc_rdata, .fp_result);
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] op(input logic [1:0] c, input logic [4:0] rd);
    return {c, rd, 5'h1, 5'h2, 15'h0};
  endfunction
  task automatic boot(input logic [31:0] p0, p1, p2, p3);
    @(negedge clock);
    rst = 1;
    ic_valid = 0;
    for (int i = 4; i < 16; i++) ssp_far_model_i.prog[i] = 32'hC000_0000;
    ssp_far_model_i.prog[0] = p0;
    ssp_far_model_i.prog[1] = p1;
    ssp_far_model_i.prog[2] = p2;
    ssp_far_model_i.prog[3] = p3;
    repeat (2) @(negedge clock);
    chk(ic_addr, 32'h100);
    chk(ic_req, 1);
    rst = 0;
    ic_valid = 1;
  endtask
  // Edges until the next commit, capped at 60
  task automatic wait_we;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (rf_we_q !== 1'b1 && n < 60);
  endtask
  task automatic t_int;
    boot(op(0, 3), op(2, 8), 32'hC000_0000, 0);
    wait_we;
    chk(n, 4);
    chk(rf_waddr_q, 3);
    chk(rf_wdata_q, 32'h3003);
    repeat (8) @(posedge clock);
    chk(ls_seen, 1);
    chk(ls_ea_q, 32'h3003);
  endtask
  task automatic t_fp;
    boot(op(1, 4), op(1, 5), op(1, 6), 32'hC000_0000);
    wait_we;
    chk(n, 6);
    chk(rf_waddr_q, 4);
    chk(rf_wdata_q, 32'h3F80_0000);
    wait_we;
    chk(n, 1);
    chk(rf_waddr_q, 5);
    wait_we;
    chk(rf_waddr_q, 6);
  endtask
  task automatic t_br;
    boot(32'hC000_4008, 32'hC000_0008, op(0, 9), op(0, 7));
    wait_we;
    chk(rf_waddr_q, 7);
    wait_we;
    chk(n, 60);
    boot(32'hC000_4008, 32'hC000_0008, op(0, 9), op(0, 7));
    br_taken = 1;
    wait_we;
    chk(rf_waddr_q, 9);
    wait_we;
    chk(rf_waddr_q, 7);
    @(negedge clock);
    br_taken = 0;
  endtask
  task automatic t_exc;
    boot(op(1, 4), 32'hC000_0000, 0, 0);
    fp_fault = 1;
    n = 0;
    while (exc_signal_q !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
      chk(rf_we_q, 0);
    end
    chk(exc_pc_q, 32'h100);
    @(negedge clock);
    fp_fault = 0;
    repeat (4) @(negedge clock);
    chk(rf_we_q, 0);
    exc_handled = 1;
    @(negedge clock);
    exc_handled = 0;
    wait_we;
    chk(rf_waddr_q, 4);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    t_int;
    t_fp;
    t_br;
    t_exc;
    tally_and_finish;
  end
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
endmodule
